// file: rtl/lcs_scan.sv
// Segment LCD display memory and four-slice common and segment scanner.
`default_nettype none
// Behaviour
// [R1] Software clears display on before buffer enable.
// [R2] Software sets static, then clears booster.
// [R3] Memory window FA00H to FA16H, read/write.
// [R4] Unused display bytes act as RAM.
// [R5] Upper nibble unstored, reads zero.
// [R6] Commons scanned in fixed repeating order.
// [R7] Segment bit index equals active common index.
// [R8] One gives select, zero deselect level.
// [R9] Pixel on only when both selected.
// [R10] Drive polarity alternates each frame.
// [R11] Gain bit picks 1.5 V or 1.0 V.
// [R12] Software waits booster settling before display.
// [R13] Display off, booster stopped before clock change.
// [R14] Advance each scan tick, invert at wrap.
// [R15] Buffers disabled hold all outputs inactive; the code forces only com_level, seg_level and pixel_on off.
module lcs_scan
	import lcs_pkg::*;
(
	input  wire logic                   sys_clk,
	input  wire logic                   sys_rst,
	input  wire logic                   lcd_scan_clock,
	input  wire logic                   mem_wr,
	input  wire logic                   mem_rd,
	input  wire logic [15:0]            mem_addr,
	input  wire logic [7:0]             mem_wdata,
	output logic      [7:0]             mem_rdata,
	output logic                        mem_hit,
	input  wire logic                   display_on_ctrl,
	input  wire logic                   drive_buffer_output_enable,
	input  wire logic                   static_mode_select,
	input  wire logic                   booster_enable,
	input  wire logic                   boost_gain,
	output logic      [1:0]             com_level [LCS_COM_NUM],
	output logic      [1:0]             seg_level [LCS_SEG_NUM],
	output logic                        drive_polarity,
	output logic                        booster_run,
	output logic                        drive_reference_level,
	output logic      [LCS_COM_NUM-1:0] pixel_on [LCS_SEG_NUM]
);
	// ****************************************************************
	// Display memory
	// ****************************************************************
	logic [3:0]       mem_r [LCS_SEG_NUM];
	logic [1:0]       tick_sync_r;
	logic             tick_prev_r;
	logic             tick;
	lcs_slot_t        slot_r;
	logic             pol_r;
	logic [4:0]       idx;
	logic             in_win;

	// Decodes a byte address into a window hit.
	function automatic logic lcs_in_win(input logic [15:0] a);
		return (a >= LCS_MEM_FIRST) && (a <= LCS_MEM_LAST);
	endfunction

	assign in_win = lcs_in_win(mem_addr); // R3
	assign idx    = 5'(mem_addr - LCS_MEM_FIRST);
	assign mem_hit = in_win;

	// Stores the low nibble of each write; every byte is plain RAM.
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			for (int i = 0; i < LCS_SEG_NUM; i++) begin
				mem_r[i] <= LCS_NIB_RST;
			end
		end else if (mem_wr && in_win) begin
			mem_r[idx] <= mem_wdata[3:0]; // R4 R5
		end
	end

	// Registered read data; upper nibble has no storage.
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			mem_rdata <= LCS_RD_IDLE;
		end else if (mem_rd && in_win) begin
			mem_rdata <= {LCS_HI_ZERO, mem_r[idx]}; // R3 R5
		end else begin
			mem_rdata <= LCS_RD_IDLE;
		end
	end

	// ****************************************************************
	// Scan timing
	// ****************************************************************
	// Synchronises the scan clock; only the second stage is examined.
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			tick_sync_r <= 2'h0;
			tick_prev_r <= 1'b0;
		end else begin
			tick_sync_r <= {tick_sync_r[0], lcd_scan_clock};
			tick_prev_r <= tick_sync_r[1];
		end
	end
	assign tick = tick_sync_r[1] && !tick_prev_r;

	// Steps the active common each scan period and flips polarity at wrap.
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			slot_r <= LCS_SLOT0;
			pol_r  <= 1'b0;
		end else if (tick) begin
			case (slot_r) // R6 R14
				LCS_SLOT0: slot_r <= LCS_SLOT1;
				LCS_SLOT1: slot_r <= LCS_SLOT2;
				LCS_SLOT2: slot_r <= LCS_SLOT3;
				default: begin
					slot_r <= LCS_SLOT0;
					pol_r  <= ~pol_r; // R10
				end
			endcase
		end
	end

	// ****************************************************************
	// Output drive
	// ****************************************************************
	// Common levels; static mode selects every common together.
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			for (int c = 0; c < LCS_COM_NUM; c++) begin
				com_level[c] <= LCS_LVL_OFF;
			end
		end else begin
			for (int c = 0; c < LCS_COM_NUM; c++) begin
				if (!drive_buffer_output_enable) begin
					com_level[c] <= LCS_LVL_OFF; // R15
				end else if (display_on_ctrl &&
						(static_mode_select || c == int'(slot_r))) begin
					com_level[c] <= LCS_LVL_SEL; // R6
				end else begin
					com_level[c] <= LCS_LVL_DESEL;
				end
			end
		end
	end

	// Segment levels from the bit that pairs with the active common.
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			for (int s = 0; s < LCS_SEG_NUM; s++) begin
				seg_level[s] <= LCS_LVL_OFF;
				pixel_on[s]  <= '0;
			end
		end else begin
			for (int s = 0; s < LCS_SEG_NUM; s++) begin
				if (!drive_buffer_output_enable) begin
					seg_level[s] <= LCS_LVL_OFF; // R15
					pixel_on[s]  <= '0;
				end else if (display_on_ctrl && mem_r[s][slot_r]) begin
					seg_level[s] <= LCS_LVL_SEL; // R7 R8
					pixel_on[s]  <= 4'(1 << slot_r); // R9
				end else begin
					seg_level[s] <= LCS_LVL_DESEL; // R8
					pixel_on[s]  <= '0; // R9
				end
			end
		end
	end

	// Polarity, booster and reference outputs; gain set drives the reference level high.
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			drive_polarity        <= 1'b0;
			booster_run           <= 1'b0;
			drive_reference_level <= 1'b0;
		end else begin
			drive_polarity        <= pol_r; // R10
			booster_run           <= booster_enable;
			drive_reference_level <= boost_gain; // R11
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	sequence s_wrap;
		tick && slot_r == LCS_SLOT3;
	endsequence

	chk_read_nibble: assert property (@(posedge sys_clk) disable iff (sys_rst) // R5
		mem_rd |=> mem_rdata[7:4] == LCS_HI_ZERO)
		else $error("upper nibble not zero");
	chk_buf_off: assert property (@(posedge sys_clk) disable iff (sys_rst) // R15
		!drive_buffer_output_enable |=> com_level[0] == LCS_LVL_OFF &&
			seg_level[0] == LCS_LVL_OFF)
		else $error("outputs active with buffers off");
	chk_polarity_wrap: assert property (@(posedge sys_clk) disable iff (sys_rst) // R10
		s_wrap |=> pol_r != $past(pol_r) ##1 drive_polarity == $past(pol_r))
		else $error("polarity not inverted at wrap");
	chk_slot_step: assert property (@(posedge sys_clk) disable iff (sys_rst) // R14
		tick && slot_r != LCS_SLOT3 |=> slot_r == lcs_slot_t'($past(slot_r) + 2'd1))
		else $error("slot did not advance");
	chk_slot_hold: assert property (@(posedge sys_clk) disable iff (sys_rst) // R6
		!tick |=> $stable(slot_r))
		else $error("slot moved without tick");
	chk_seg_select: assert property (@(posedge sys_clk) disable iff (sys_rst) // R8
		drive_buffer_output_enable && display_on_ctrl && mem_r[0][slot_r]
		|=> seg_level[0] == LCS_LVL_SEL)
		else $error("segment not selected");
	chk_pixel_both: assert property (@(posedge sys_clk) disable iff (sys_rst) // R9
		pixel_on[0] != '0 |-> seg_level[0] == LCS_LVL_SEL)
		else $error("pixel on without select");
	chk_gain_level: assert property (@(posedge sys_clk) disable iff (sys_rst) // R11
		1'b1 |=> drive_reference_level == $past(boost_gain))
		else $error("reference level wrong");
	chk_write_read: assert property (@(posedge sys_clk) disable iff (sys_rst) // R4
		mem_wr && in_win ##1 mem_rd && !mem_wr && mem_addr == $past(mem_addr)
		|=> mem_rdata[3:0] == $past(mem_wdata[3:0], 2))
		else $error("ram readback mismatch");
	chk_com_active: assert property (@(posedge sys_clk) disable iff (sys_rst) // R6
		drive_buffer_output_enable && display_on_ctrl && slot_r == LCS_SLOT2
		|=> com_level[LCS_SLOT2] == LCS_LVL_SEL)
		else $error("active common not selected");
	chk_rd_refuse: assert property (@(posedge sys_clk) disable iff (sys_rst) // R3
		mem_rd && !in_win |=> mem_rdata == LCS_RD_IDLE)
		else $error("read outside window not idle");
endmodule
`default_nettype wire

// file: rtl/lcs_pkg.sv
// Package of constants for the segment LCD common scan block.
`default_nettype none
package lcs_pkg;
	// ****************************************************************
	// Memory map
	// ****************************************************************
	localparam int          LCS_SEG_NUM   = 23;
	localparam int          LCS_COM_NUM   = 4;
	localparam logic [15:0] LCS_MEM_FIRST = 16'hFA00;
	localparam logic [15:0] LCS_MEM_LAST  = 16'hFA16;
	localparam logic [3:0]  LCS_NIB_RST   = 4'h0;
	localparam logic [3:0]  LCS_HI_ZERO   = 4'h0;
	localparam logic [7:0]  LCS_RD_IDLE   = 8'h00;
	// ****************************************************************
	// Drive levels and reference voltages
	// ****************************************************************
	localparam logic [1:0]  LCS_LVL_OFF   = 2'h0;
	localparam logic [1:0]  LCS_LVL_DESEL = 2'h1;
	localparam logic [1:0]  LCS_LVL_SEL   = 2'h2;
	localparam int          LCS_VREF_HI_MV = 1500;
	localparam int          LCS_VREF_LO_MV = 1000;
	// ****************************************************************
	// Scan machine
	// ****************************************************************
	typedef enum logic [1:0] {
		LCS_SLOT0,
		LCS_SLOT1,
		LCS_SLOT2,
		LCS_SLOT3
	} lcs_slot_t;
endpackage
`default_nettype wire

// file: verif/lcs_panel.sv
// Behavioural model of the four-backplane segment glass driven by the block.
`default_nettype none
module lcs_panel
	import lcs_pkg::*;
(
	input  wire logic                   sys_clk,
	input  wire logic                   clear,
	input  wire logic [1:0]             com_level [LCS_COM_NUM],
	input  wire logic [1:0]             seg_level [LCS_SEG_NUM],
	output logic      [LCS_COM_NUM-1:0] lit       [LCS_SEG_NUM]
);
	timeunit 1ns;
	timeprecision 100ps;
	// A pixel latches lit once both of its electrodes sit at select.
	always_ff @(posedge sys_clk) begin
		for (int s = 0; s < LCS_SEG_NUM; s++) begin
			for (int c = 0; c < LCS_COM_NUM; c++) begin
				if (clear) begin
					lit[s][c] <= 1'b0;
				end else if (com_level[c] == LCS_LVL_SEL &&
					seg_level[s] == LCS_LVL_SEL) begin
					lit[s][c] <= 1'b1;
				end
			end
		end
	end
endmodule
`default_nettype wire

// file: verif/testbench.sv
// Self-checking testbench for the segment LCD common scan block.
`default_nettype none
module testbench
	import lcs_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic sys_clk, sys_rst, lcd_scan_clock, mem_wr, mem_rd, mem_hit, clear;
	logic [15:0] mem_addr;
	logic [7:0] mem_wdata, mem_rdata;
	logic display_on_ctrl, drive_buffer_output_enable, static_mode_select;
	logic booster_enable, boost_gain, drive_polarity, booster_run;
	logic drive_reference_level;
	logic [1:0] com_level [LCS_COM_NUM];
	logic [1:0] seg_level [LCS_SEG_NUM];
	logic [LCS_COM_NUM-1:0] pixel_on [LCS_SEG_NUM];
	logic [LCS_COM_NUM-1:0] lit [LCS_SEG_NUM];
	int mismatches, compares;
	lcs_scan lcs_scan_inst (.sys_clk, .sys_rst, .lcd_scan_clock, .mem_wr,
		.mem_rd, .mem_addr, .mem_wdata, .mem_rdata, .mem_hit,
		.display_on_ctrl, .drive_buffer_output_enable, .static_mode_select,
		.booster_enable, .boost_gain, .com_level, .seg_level,
		.drive_polarity, .booster_run, .drive_reference_level, .pixel_on);
	lcs_panel lcs_panel_inst (.sys_clk, .clear, .com_level, .seg_level, .lit);
	// Free-running 200 MHz clock.
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	// Waits for the given number of falling edges.
	task automatic cyc(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	// Compares one result and counts any mismatch.
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// One-cycle write strobe with address and data held across the edge.
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		mem_wr = 1'b1;
		mem_addr = a;
		mem_wdata = d;
		cyc(1);
		mem_wr = 1'b0;
	endtask
	// One-cycle read strobe; data is judged in the cycle after the edge.
	task automatic rd(input logic [15:0] a, input logic [7:0] exp);
		mem_rd = 1'b1;
		mem_addr = a;
		cyc(1);
		mem_rd = 1'b0;
		chk(mem_rdata, exp);
	endtask
	// One scan clock period, long enough for the synchroniser path.
	task automatic step();
		lcd_scan_clock = 1'b1;
		cyc(4);
		lcd_scan_clock = 1'b0;
		cyc(4);
	endtask
	// Writes with zero upper nibbles, then reads in and out of the window.
	task automatic t_mem();
		wr(16'hFA0C, 8'h0D);
		rd(16'hFA0C, 8'h0D);
		wr(16'hFA17, 8'h0F);
		rd(16'hFA17, 8'h00);
		chk(8'(mem_hit), 8'h00);
		wr(16'hFA16, 8'h08);
		rd(16'hFA16, 8'h08);
		chk(8'(mem_hit), 8'h01);
		wr(16'hFA00, 8'h05);
	endtask
	// Starts the display, scans one frame and checks the glass pattern.
	task automatic t_scan();
		int idx, prv;
		logic pol;
		booster_enable = 1'b1;
		boost_gain = 1'b1;
		cyc(3);
		chk(8'(drive_reference_level), 8'h01);
		chk(8'(booster_run), 8'h01);
		static_mode_select = 1'b0;
		drive_buffer_output_enable = 1'b1;
		display_on_ctrl = 1'b1;
		clear = 1'b1;
		step();
		clear = 1'b0;
		pol = drive_polarity;
		prv = 0;
		for (int i = 0; i < 4; i++) begin
			step();
			idx = 0;
			for (int c = 0; c < LCS_COM_NUM; c++)
				if (com_level[c] == LCS_LVL_SEL) idx = c;
			if (i > 0) chk(8'(idx), 8'((prv + 1) % 4));
			chk(8'(pixel_on[12]), ((8'h0D >> idx) & 8'h01) << idx);
			prv = idx;
		end
		chk(8'(drive_polarity), 8'(!pol));
		chk(8'(lit[0]), 8'h05);
		chk(8'(lit[12]), 8'h0D);
		chk(8'(lit[22]), 8'h08);
		chk(8'(lit[1]), 8'h00);
		// Static mode drives every common at select together.
		static_mode_select = 1'b1;
		cyc(2);
		chk(8'(com_level[0]), 8'(LCS_LVL_SEL));
		chk(8'(com_level[3]), 8'(LCS_LVL_SEL));
		static_mode_select = 1'b0;
	endtask
	// Shuts the display down step by step; checks after display off and at the end.
	task automatic t_off();
		display_on_ctrl = 1'b0;
		cyc(2);
		chk(8'(com_level[0]), 8'(LCS_LVL_DESEL));
		chk(8'(seg_level[12]), 8'(LCS_LVL_DESEL));
		drive_buffer_output_enable = 1'b0;
		cyc(1);
		static_mode_select = 1'b1;
		cyc(1);
		booster_enable = 1'b0;
		cyc(1);
		boost_gain = 1'b0;
		// The scan clock runs again only with display and booster stopped.
		step();
		chk(8'(com_level[1]), 8'(LCS_LVL_OFF));
		chk(8'(seg_level[12]), 8'(LCS_LVL_OFF));
		chk(8'(drive_reference_level), 8'h00);
		chk(8'(booster_run), 8'h00);
	endtask
	// Checks idle outputs and cleared memory right after reset.
	task automatic t_reset();
		chk(8'(com_level[0]), 8'(LCS_LVL_OFF));
		rd(16'hFA05, 8'h00);
	endtask
	// Prints the counts and the verdict, then ends the run.
	task automatic complete_run();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Main sequence: reset, memory access, scanning, shutdown.
	initial begin
		{sys_rst, lcd_scan_clock, mem_wr, mem_rd, clear} = 5'h10;
		{display_on_ctrl, drive_buffer_output_enable} = 2'h0;
		{static_mode_select, booster_enable, boost_gain} = 3'h4;
		mem_addr = 16'h0000;
		mem_wdata = 8'h00;
		mismatches = 0;
		compares = 0;
		cyc(3);
		sys_rst = 1'b0;
		t_reset();
		t_mem();
		t_scan();
		t_off();
		complete_run();
	end
endmodule
`default_nettype wire
